// file: src/swm_defs.svh
// Purpose: constants shared by the switch matrix serial control block
// Assumes: seven-bit two-wire slave address, six 2:1 multiplexers
// Notes:   constants only, no logic
`ifndef SWM_DEFS_SVH
`define SWM_DEFS_SVH

`define ADDR_FIXED_HI  5'h14
`define ADDR_RESET     7'h50
`define MUX_COUNT      6
`define BIT_FIRST      4'h0
`define BIT_ACK        4'h8
`define SEL_ALL_A      7'h00
`define SEL_ALL_B      7'h01
`define SEL_SW_FIRST   7'h02
`define SEL_SW_LAST    7'h0d
`define SEL_DIS_FIRST  7'h0e
`define SEL_DIS_LAST   7'h13
`define SEL_ALL_DIS    7'h1f
`define CMD_ON_BIT     7
`define MODE_LOAD_BIT  1
`define MODE_RSTN_BIT  0
`define SW_OPEN_ALL    6'h00
`define BYTE_ZERO      8'h00
`define STATUS_PAD     2'h0

`endif

// file: src/swm_pkg.sv
// Purpose: types shared by the switch matrix serial control block
// Assumes: nothing beyond the defs header
// Notes:   types only
`default_nettype none

package swm_pkg;
  // position within a framed transfer on the serial link
  typedef enum {
    LINK_ADDR,
    LINK_WRITE,
    LINK_READ,
    LINK_IGNORE
  } link_state_t;

  // one bit per multiplexer, bit 0 is multiplexer 1
  typedef logic [5:0] mux_vec_t;
endpackage

`default_nettype wire

// file: src/swm_cmd_if.sv
// Purpose: command word and switch state between link side and switch bank
// Assumes: valid and switch state on the system clock, cmd and mode from scl-side registers
// Notes:   valid is a one-cycle pulse, cmd and mode stand while it is high
`default_nettype none

interface swm_cmd_if;
  logic              valid;
  logic [7:0]        cmd;
  logic [7:0]        mode;
  swm_pkg::mux_vec_t act_a;
  swm_pkg::mux_vec_t act_b;
  swm_pkg::mux_vec_t pend_a;
  swm_pkg::mux_vec_t pend_b;

  modport link (output valid, output cmd, output mode,
                input act_a, input act_b, input pend_a, input pend_b);
  modport bank (input valid, input cmd, input mode,
                output act_a, output act_b, output pend_a, output pend_b);
endinterface

`default_nettype wire

// file: src/swm_switch_bank.sv
// Purpose: decode switch commands into pending and active switch state
// Assumes: one command word per valid pulse
// Notes:   reserved selectors leave the pending state untouched; the mode bits still load or clear
`include "swm_defs.svh"
`default_nettype none

module swm_switch_bank (
  input  wire logic clk_sys_i,
  input  wire logic rst_n_i,
  swm_cmd_if.bank   cmd_port
);
  // ----------------------------------------
  // command decode
  // ----------------------------------------
  logic [6:0]        sel;
  logic [6:0]        sw_idx;
  logic [6:0]        dis_idx;
  logic              sw_on;
  logic              is_sw;
  logic              is_dis;
  logic              all_dis;
  logic              do_load;
  logic              keep_on;
  swm_pkg::mux_vec_t pend_a_reg;
  swm_pkg::mux_vec_t pend_b_reg;
  swm_pkg::mux_vec_t act_a_reg;
  swm_pkg::mux_vec_t act_b_reg;
  swm_pkg::mux_vec_t pend_a_next;
  swm_pkg::mux_vec_t pend_b_next;

  // top bit is on/off, the rest select a switch or a mux
  assign sel     = cmd_port.cmd[6:0];
  assign sw_on   = cmd_port.cmd[`CMD_ON_BIT];
  assign sw_idx  = sel - `SEL_SW_FIRST;
  assign dis_idx = sel - `SEL_DIS_FIRST;
  assign is_sw   = (sel >= `SEL_SW_FIRST) && (sel <= `SEL_SW_LAST);
  assign is_dis  = (sel >= `SEL_DIS_FIRST) && (sel <= `SEL_DIS_LAST);
  assign all_dis = (sel == `SEL_ALL_DIS) && !sw_on;
  assign do_load = cmd_port.mode[`MODE_LOAD_BIT];
  assign keep_on = cmd_port.mode[`MODE_RSTN_BIT];

  // per mux: closing one side opens the other, so the latest command wins
  for (genvar i = 0; i < `MUX_COUNT; i++) begin : g_mux
    logic hit_a;
    logic hit_b;
    logic off;
    assign hit_a = (sel == `SEL_ALL_A) | (is_sw & (sw_idx[3:1] == 3'(i)) & ~sw_idx[0]);
    assign hit_b = (sel == `SEL_ALL_B) | (is_sw & (sw_idx[3:1] == 3'(i)) & sw_idx[0]);
    assign off   = (is_dis & (dis_idx == 7'(i))) | all_dis;
    assign pend_a_next[i] = off ? 1'b0 : hit_a ? sw_on :
                            (hit_b & sw_on) ? 1'b0 : pend_a_reg[i];
    assign pend_b_next[i] = off ? 1'b0 : hit_b ? sw_on :
                            (hit_a & sw_on) ? 1'b0 : pend_b_reg[i];
  end

  // ----------------------------------------
  // pending and active state
  // ----------------------------------------
  // a soft reset clears both copies so a later load cannot resurrect old state
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i || (cmd_port.valid && !keep_on)) begin
      pend_a_reg <= `SW_OPEN_ALL;
      pend_b_reg <= `SW_OPEN_ALL;
      act_a_reg  <= `SW_OPEN_ALL;
      act_b_reg  <= `SW_OPEN_ALL;
    end else if (cmd_port.valid) begin
      pend_a_reg <= pend_a_next;
      pend_b_reg <= pend_b_next;
      if (do_load) begin
        act_a_reg <= pend_a_next;
        act_b_reg <= pend_b_next;
      end
    end
  end

  assign cmd_port.act_a  = act_a_reg;
  assign cmd_port.act_b  = act_b_reg;
  assign cmd_port.pend_a = pend_a_reg;
  assign cmd_port.pend_b = pend_b_reg;
endmodule // swm_switch_bank

`default_nettype wire

// file: src/swm_serial_top.sv
// Purpose: two-wire slave link and command path of the switch matrix
// Assumes: scl_clk_i comes from the bus master and stops between frames
// Notes:   framing runs on scl, decode and switch state on clk_sys_i
`include "swm_defs.svh"
`default_nettype none

module swm_serial_top (
  input  wire logic clk_sys_i,
  input  wire logic rst_n_i,
  input  wire logic scl_clk_i,
  input  wire logic sda_i,
  output logic      sda_o,
  output logic      sda_oe_o,
  input  wire logic addr_select_bit0_i,
  input  wire logic addr_select_bit1_i,
  output logic      bus_busy_o,
  output logic [5:0] switch_a_closed_o,
  output logic [5:0] switch_b_closed_o,
  output logic [5:0] pending_a_closed_o,
  output logic [5:0] pending_b_closed_o
);
  // ----------------------------------------
  // system side declarations
  // ----------------------------------------
  logic [1:0]        scl_sync_reg;
  logic [1:0]        sda_sync_reg;
  logic [1:0]        asel_s1_reg;
  logic [1:0]        asel_s2_reg;
  logic              scl_prev_reg;
  logic              sda_prev_reg;
  logic              start_det;
  logic              stop_det;
  logic              bus_idle_reg;
  logic              bus_idle_next;
  logic              hold_reg;
  logic              link_rst_reg;
  logic [6:0]        addr_hold_reg;
  logic [7:0]        status0_hold_reg;
  logic [7:0]        status1_hold_reg;
  logic [1:0]        tog_sync_reg;
  logic              tog_prev_reg;
  logic              word_valid;

  // ----------------------------------------
  // link side declarations
  // ----------------------------------------
  swm_pkg::link_state_t state_reg;
  swm_pkg::link_state_t state_next;
  logic [3:0]        cnt_reg;
  logic [3:0]        cnt_next;
  logic [7:0]        shift_reg;
  logic [7:0]        shift_next;
  logic              second_reg;
  logic              second_next;
  logic              at_ack;
  logic              addr_hit;
  logic              dir_read;
  logic              master_ack;
  logic              cmd_take;
  logic              word_take;
  logic [7:0]        cmd_stage_reg;
  logic [7:0]        cmd_word_reg;
  logic [7:0]        mode_word_reg;
  logic              word_tog_reg;
  logic              drive_next;
  logic              sda_drive_reg;

  swm_cmd_if cmd_bus ();

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  // first stage feeds only the second; edge logic looks at stage two
  always_ff @(posedge clk_sys_i) begin
    scl_sync_reg <= {scl_sync_reg[0], scl_clk_i};
    sda_sync_reg <= {sda_sync_reg[0], sda_i};
    asel_s1_reg  <= {addr_select_bit1_i, addr_select_bit0_i};
    asel_s2_reg  <= asel_s1_reg;
  end

  // previous sample of the synchronised lines
  always_ff @(posedge clk_sys_i) begin
    scl_prev_reg <= scl_sync_reg[1];
    sda_prev_reg <= sda_sync_reg[1];
  end

  // ----------------------------------------
  // start and stop detection
  // ----------------------------------------
  // only the master moves sda while scl is high, so these are unambiguous
  assign start_det = scl_sync_reg[1] & scl_prev_reg &
                     ~sda_sync_reg[1] & sda_prev_reg;
  assign stop_det  = scl_sync_reg[1] & scl_prev_reg &
                     sda_sync_reg[1] & ~sda_prev_reg;

  assign bus_idle_next = stop_det ? 1'b1 :
                         start_det ? 1'b0 : bus_idle_reg;

  // hold keeps the scl logic cleared between frames and pulses on
  // every start, so a repeated start re-aligns the bit counter
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      bus_idle_reg <= 1'b1;
      hold_reg     <= 1'b1;
      link_rst_reg <= 1'b1;
    end else begin
      bus_idle_reg <= bus_idle_next;
      hold_reg     <= bus_idle_next | start_det;
      link_rst_reg <= 1'b0;
    end
  end

  // ----------------------------------------
  // quasi-static values for the link side
  // ----------------------------------------
  // these only move while the bus is idle, so scl logic reads them
  // without a synchroniser; a read right after a write in one frame
  // shows the state from before that frame
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      addr_hold_reg    <= `ADDR_RESET;
      status0_hold_reg <= `BYTE_ZERO;
      status1_hold_reg <= `BYTE_ZERO;
    end else if (bus_idle_reg) begin
      addr_hold_reg    <= {`ADDR_FIXED_HI, asel_s2_reg};
      status0_hold_reg <= {`STATUS_PAD, cmd_bus.act_a};
      status1_hold_reg <= {`STATUS_PAD, cmd_bus.act_b};
    end
  end

  // ----------------------------------------
  // word crossing into the system clock
  // ----------------------------------------
  // toggle carries the event; the word regs stand for many scl periods
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      tog_sync_reg <= 2'h0;
      tog_prev_reg <= 1'b0;
    end else begin
      tog_sync_reg <= {tog_sync_reg[0], word_tog_reg};
      tog_prev_reg <= tog_sync_reg[1];
    end
  end

  assign word_valid    = tog_sync_reg[1] ^ tog_prev_reg;
  assign cmd_bus.valid = word_valid;
  assign cmd_bus.cmd   = cmd_word_reg;
  assign cmd_bus.mode  = mode_word_reg;

  swm_switch_bank u_bank (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .cmd_port  (cmd_bus.bank)
  );

  // ----------------------------------------
  // link framing decode
  // ----------------------------------------
  assign at_ack     = (cnt_reg == `BIT_ACK);
  assign addr_hit   = (shift_reg[7:1] == addr_hold_reg);
  assign dir_read   = shift_reg[0];
  assign master_ack = ~sda_i;
  assign cmd_take   = (state_reg == swm_pkg::LINK_WRITE) & at_ack & ~second_reg;
  assign word_take  = (state_reg == swm_pkg::LINK_WRITE) & at_ack & second_reg;

  // ----------------------------------------
  // link next state, evaluated for each rising scl
  // ----------------------------------------
  always_comb begin
    state_next  = state_reg;
    second_next = second_reg;
    shift_next  = {shift_reg[6:0], sda_i};
    cnt_next    = at_ack ? `BIT_FIRST : cnt_reg + 4'h1;
    unique case (state_reg)
      swm_pkg::LINK_ADDR: begin
        if (at_ack) begin
          shift_next = shift_reg;
          if (!addr_hit) begin
            state_next = swm_pkg::LINK_IGNORE;
          end else if (dir_read) begin
            state_next = swm_pkg::LINK_READ;
            shift_next = status0_hold_reg;
          end else begin
            state_next = swm_pkg::LINK_WRITE;
          end
        end
      end
      swm_pkg::LINK_WRITE: begin
        if (at_ack) begin
          shift_next  = shift_reg;
          second_next = ~second_reg;
        end
      end
      swm_pkg::LINK_READ: begin
        shift_next = {shift_reg[6:0], 1'b0};
        if (at_ack) begin
          if (master_ack && !second_reg) begin
            shift_next  = status1_hold_reg;
            second_next = 1'b1;
          end else begin
            state_next = swm_pkg::LINK_IGNORE;
          end
        end
      end
      swm_pkg::LINK_IGNORE: begin
        cnt_next   = cnt_reg;
        shift_next = shift_reg;
      end
    endcase
  end

  // ----------------------------------------
  // link registers on rising scl
  // ----------------------------------------
  // hold is a registered system-side level, used as async clear
  always_ff @(posedge scl_clk_i or posedge hold_reg) begin
    if (hold_reg) begin
      state_reg  <= swm_pkg::LINK_ADDR;
      cnt_reg    <= `BIT_FIRST;
      shift_reg  <= `BYTE_ZERO;
      second_reg <= 1'b0;
    end else begin
      state_reg  <= state_next;
      cnt_reg    <= cnt_next;
      shift_reg  <= shift_next;
      second_reg <= second_next;
    end
  end

  // ----------------------------------------
  // captured command word
  // ----------------------------------------
  // kept apart from the frame clear so a stop cannot fake a new word
  always_ff @(posedge scl_clk_i or posedge link_rst_reg) begin
    if (link_rst_reg) begin
      cmd_stage_reg <= `BYTE_ZERO;
      cmd_word_reg  <= `BYTE_ZERO;
      mode_word_reg <= `BYTE_ZERO;
      word_tog_reg  <= 1'b0;
    end else if (cmd_take) begin
      cmd_stage_reg <= shift_reg;
    end else if (word_take) begin
      cmd_word_reg  <= cmd_stage_reg;
      mode_word_reg <= shift_reg;
      word_tog_reg  <= ~word_tog_reg;
    end
  end

  // ----------------------------------------
  // sda driver on falling scl
  // ----------------------------------------
  // acks for a matching address and every written byte; read data bits
  // pull low for zero; the master's ack slot is always released
  assign drive_next =
    ((state_reg == swm_pkg::LINK_ADDR) & at_ack & addr_hit) |
    ((state_reg == swm_pkg::LINK_WRITE) & at_ack) |
    ((state_reg == swm_pkg::LINK_READ) & ~at_ack & ~shift_reg[7]);

  // changing on the falling edge keeps sda still while scl is high
  always_ff @(negedge scl_clk_i or posedge hold_reg) begin
    if (hold_reg) begin
      sda_drive_reg <= 1'b0;
    end else begin
      sda_drive_reg <= drive_next;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  // open drain: only ever pull low; there is no scl driver at all
  assign sda_o              = 1'b0;
  assign sda_oe_o           = sda_drive_reg;
  assign bus_busy_o         = ~bus_idle_reg;
  assign switch_a_closed_o  = cmd_bus.act_a;
  assign switch_b_closed_o  = cmd_bus.act_b;
  assign pending_a_closed_o = cmd_bus.pend_a;
  assign pending_b_closed_o = cmd_bus.pend_b;
endmodule // swm_serial_top

`default_nettype wire

// file: verification/swm_serial_top_sva.sv
// Purpose: port-level checks of the switch matrix serial control
// Assumes: scl and sda never move on a clk_sys_i edge
// Notes:   bound to swm_serial_top below
`include "swm_defs.svh"
`default_nettype none

module swm_serial_top_sva (
  input wire logic       clk_sys_i,
  input wire logic       rst_n_i,
  input wire logic       scl_clk_i,
  input wire logic       sda_i,
  input wire logic       sda_o,
  input wire logic       sda_oe_o,
  input wire logic       addr_select_bit0_i,
  input wire logic       addr_select_bit1_i,
  input wire logic       bus_busy_o,
  input wire logic [5:0] switch_a_closed_o,
  input wire logic [5:0] switch_b_closed_o,
  input wire logic [5:0] pending_a_closed_o,
  input wire logic [5:0] pending_b_closed_o
);
  // --------
  // wire view
  // --------
  logic       scl_q;
  logic       sda_q;
  logic       in_addr;
  logic [3:0] bit_cnt;
  logic [7:0] shift_q;
  wire logic  scl_rise = scl_clk_i && !scl_q;
  wire logic  start_ev = scl_clk_i && scl_q && sda_q && !sda_i;
  wire logic  stop_ev  = scl_clk_i && scl_q && !sda_q && sda_i;
  wire logic  addr_hit = shift_q[7:1] == {`ADDR_FIXED_HI, addr_select_bit1_i, addr_select_bit0_i};

  // own copy of the address byte, so the ack is judged without the design's view
  always_ff @(posedge clk_sys_i) begin
    scl_q <= scl_clk_i;
    sda_q <= sda_i;
    if (!rst_n_i || stop_ev) begin
      in_addr <= 1'b0;
      bit_cnt <= 4'h0;
    end else if (start_ev) begin
      in_addr <= 1'b1;
      bit_cnt <= 4'h0;
    end else if (scl_rise && in_addr) begin
      bit_cnt <= bit_cnt + 4'h1;
      shift_q <= {shift_q[6:0], sda_i};
      in_addr <= bit_cnt != 4'h8;
    end
  end

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  sequence start_seq; start_ev; endsequence
  sequence stop_seq; stop_ev; endsequence
  sequence ack_slot_seq; scl_rise && in_addr && bit_cnt == 4'h8; endsequence

  ack_match_a: assert property (ack_slot_seq |-> sda_oe_o == addr_hit)
    else $error("address ack disagrees with match");
  addr_quiet_a: assert property (ack_slot_seq ##0 !addr_hit |=> !sda_oe_o [*8])
    else $error("drive after foreign address");
  start_busy_a: assert property (start_seq |-> ##[1:5] bus_busy_o)
    else $error("start not flagged busy");
  stop_idle_a: assert property (stop_seq |-> ##[1:5] !bus_busy_o)
    else $error("stop not ending busy");
  idle_quiet_a: assert property (!bus_busy_o [*2] |-> !sda_oe_o)
    else $error("sda driven while idle");
  scl_hold_a: assert property (scl_clk_i && scl_q |-> $stable(sda_oe_o))
    else $error("sda moved while scl high");
  one_side_a: assert property (((switch_a_closed_o & switch_b_closed_o) |
    (pending_a_closed_o & pending_b_closed_o)) == 6'h00) else $error("two switches of a mux");
  load_copy_a: assert property ($changed(switch_a_closed_o) || $changed(switch_b_closed_o)
    |-> switch_a_closed_o == pending_a_closed_o && switch_b_closed_o == pending_b_closed_o)
    else $error("active state not taken from pending");
  sda_zero_a: assert property (sda_o == 1'b0)
    else $error("sda data value not low");
endmodule // swm_serial_top_sva

bind swm_serial_top swm_serial_top_sva i_swm_serial_top_sva (
  .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .scl_clk_i(scl_clk_i), .sda_i(sda_i),
  .sda_o(sda_o), .sda_oe_o(sda_oe_o), .addr_select_bit0_i(addr_select_bit0_i),
  .addr_select_bit1_i(addr_select_bit1_i), .bus_busy_o(bus_busy_o),
  .switch_a_closed_o(switch_a_closed_o), .switch_b_closed_o(switch_b_closed_o),
  .pending_a_closed_o(pending_a_closed_o), .pending_b_closed_o(pending_b_closed_o));

`default_nettype wire

// file: verification/swm_bus_master.sv
// Purpose: behavioural two-wire bus master facing the switch matrix
// Assumes: sda pull-up resolved by the bench
// Notes:   entered at an odd ns offset, edges spaced by even steps, so no edge meets a rising clk_sys edge
`default_nettype none

module swm_bus_master (
  output logic      scl_o,
  output logic      sda_low_o,
  input  wire logic sda_i
);
  timeunit 1ns;
  timeprecision 100ps;
  // --------
  // bit level
  // --------
  int         gap;
  logic       ack_seen;
  logic [7:0] rd_q [2];

  // parked bus: clock stands high, data released
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
    gap = 0;
  end

  // one pulse; gap stretches the low phase for a slow master
  task automatic pulse(input logic b, output logic got);
    #6 sda_low_o = !b;
    #(18 + gap) scl_o = 1'b1;
    #1 got = sda_i;
    #23 scl_o = 1'b0;
  endtask

  task automatic frame(input logic [6:0] ad, input logic rd, input int nb,
                       input logic [7:0] wb [4]);
    logic       got;
    logic [7:0] v;
    sda_low_o = 1'b1;
    #42 scl_o = 1'b0;
    v = {ad, rd};
    for (int i = 7; i >= 0; i--) pulse(v[i], got);
    pulse(1'b1, got);
    ack_seen = !got;
    for (int k = 0; k < nb && ack_seen; k++) begin
      for (int i = 7; i >= 0; i--) begin
        pulse(rd ? 1'b1 : wb[k][i], got);
        v[i] = got;
      end
      if (rd) rd_q[k] = v;
      pulse(!rd || k == nb - 1, got);
    end
    #6 sda_low_o = 1'b1;
    #18 scl_o = 1'b1;
    #12 sda_low_o = 1'b0;
    #24;
  endtask
endmodule // swm_bus_master

`default_nettype wire

// file: verification/i2c_switch_matrix_control_tb_top.sv
// Purpose: self-checking bench for the switch matrix serial control
// Assumes: master model owns scl and pulls sda
// Notes:   one note per frame, judged after bus_busy_o falls
`default_nettype none

`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin mismatches++; \
  $display("[ERR] %0t got %h exp %h", $time, g, e); end end

module i2c_switch_matrix_control_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  // --------
  // bench
  // --------
  typedef struct {logic ack; logic rd; logic [5:0] a, b, pa, pb;} note_t;
  localparam logic [6:0] DEV_ADDR = 7'h50;
  logic        clk_sys, rst_n, a0, a1, scl, sda_low, sda_o_w, sda_oe, busy;
  logic [5:0]  sw_a, sw_b, pd_a, pd_b, ea, eb, pa, pb;
  logic [31:0] rnd;
  int          mismatches, cmp_count, cyc;
  note_t       notes [$];
  note_t       n;
  wire logic   sda_line = !(sda_low || (sda_oe && !sda_o_w));

  swm_serial_top i_swm_serial_top (.clk_sys_i(clk_sys), .rst_n_i(rst_n), .scl_clk_i(scl),
    .sda_i(sda_line), .sda_o(sda_o_w), .sda_oe_o(sda_oe), .addr_select_bit0_i(a0),
    .addr_select_bit1_i(a1), .bus_busy_o(busy), .switch_a_closed_o(sw_a),
    .switch_b_closed_o(sw_b), .pending_a_closed_o(pd_a), .pending_b_closed_o(pd_b));
  swm_bus_master i_swm_bus_master (.scl_o(scl), .sda_low_o(sda_low), .sda_i(sda_line));

  always #5 clk_sys = !clk_sys;

  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] x;
    x = v ^ (v << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  // expected switch state; closing one side of a mux opens the other
  task automatic apply(input logic [7:0] c, input logic [7:0] m);
    logic [6:0] s;
    int         mx;
    s = c[6:0];
    mx = int'(s - 7'h02) / 2;
    if (!m[0]) begin
      {pa, pb, ea, eb} = 24'h000000;
      return;
    end
    if (s == 7'h00) {pa, pb} = c[7] ? {6'h3f, 6'h00} : {6'h00, pb};
    else if (s == 7'h01) {pa, pb} = c[7] ? {6'h00, 6'h3f} : {pa, 6'h00};
    else if (s >= 7'h02 && s <= 7'h0d && s[0]) {pa[mx], pb[mx]} = {pa[mx] & !c[7], c[7]};
    else if (s >= 7'h02 && s <= 7'h0d) {pa[mx], pb[mx]} = {c[7], pb[mx] & !c[7]};
    else if (s >= 7'h0e && s <= 7'h13) {pa[int'(s) - 14], pb[int'(s) - 14]} = 2'h0;
    else if (s == 7'h1f && !c[7]) {pa, pb} = 12'h000;
    if (m[1]) {ea, eb} = {pa, pb};
  endtask

  task automatic idle();
    repeat (12) @(posedge clk_sys);
    #3;
  endtask

  task automatic push(input logic ack, input logic rd);
    notes.push_back('{ack, rd, ea, eb, pa, pb});
  endtask

  task automatic wr(input logic [6:0] ad, input logic hit, input int nb, input logic [7:0] b [4]);
    if (hit && nb > 1) apply(b[0], b[1]);
    if (hit && nb > 3) apply(b[2], b[3]);
    push(hit, 1'b0);
    i_swm_bus_master.frame(ad, 1'b0, nb, b);
    idle();
  endtask

  task automatic wr1(input logic [6:0] ad, input logic [7:0] c, input logic [7:0] m,
                     input logic hit);
    wr(ad, hit, 2, '{c, m, 8'h00, 8'h00});
  endtask

  task automatic rdf();
    push(1'b1, 1'b1);
    i_swm_bus_master.frame(DEV_ADDR, 1'b1, 2, '{default: 8'h00});
    idle();
  endtask

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // result watcher: oldest note against the outputs once the frame closed
  // busy leaves X for 0 at the first reset edge; that false edge is not a frame
  always @(negedge busy) if (rst_n) begin
    repeat (4) @(posedge clk_sys);
    if (notes.size() == 0) begin
      mismatches++;
      $display("[ERR] %0t frame without note", $time);
    end else begin
      n = notes.pop_front();
      `CHK(i_swm_bus_master.ack_seen, n.ack)
      `CHK(sw_a, n.a)
      `CHK(sw_b, n.b)
      `CHK(pd_a, n.pa)
      `CHK(pd_b, n.pb)
      if (n.rd) begin
        `CHK(i_swm_bus_master.rd_q[0], {2'h0, n.a})
        `CHK(i_swm_bus_master.rd_q[1], {2'h0, n.b})
      end
    end
  end

  // hang guard, well above the expected run length
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 60000) begin
      mismatches++;
      $display("[ERR] %0t timeout", $time);
      test_done();
    end
  end

  // main sequence
  initial begin
    {clk_sys, rst_n, a0, a1} = 4'h0;
    {ea, eb, pa, pb} = 24'h000000;
    rnd = 32'h00006c4a;
    repeat (12) @(posedge clk_sys);
    #3 rst_n = 1'b1;
    idle();
    rdf();
    for (int s = 0; s < 4; s++) begin
      {a1, a0} = 2'(s);
      idle();
      wr1({5'h14, 2'(s)}, 8'h82, 8'h03, 1'b1);
      wr1({5'h14, 2'(s ^ 1)}, 8'h83, 8'h03, 1'b0);
      wr1({5'h15, 2'(s)}, 8'h83, 8'h03, 1'b0);
    end
    {a1, a0} = 2'h0;
    idle();
    wr1(DEV_ADDR, 8'h84, 8'h01, 1'b1);
    wr1(DEV_ADDR, 8'h87, 8'h01, 1'b1);
    rdf();
    wr1(DEV_ADDR, 8'h8c, 8'h03, 1'b1);
    wr1(DEV_ADDR, 8'h83, 8'h03, 1'b1);
    wr(DEV_ADDR, 1'b1, 4, '{8'h85, 8'h01, 8'h8a, 8'h03});
    wr(DEV_ADDR, 1'b1, 1, '{8'h0e, 8'h00, 8'h00, 8'h00});
    wr(DEV_ADDR, 1'b1, 3, '{8'h86, 8'h03, 8'h0f, 8'h00});
    wr1(DEV_ADDR, 8'h84, 8'h02, 1'b1);
    for (int s = 0; s < 64; s++) wr1(DEV_ADDR, 8'(s), 8'h03, 1'b1);
    for (int i = 0; i < 30; i++) begin
      rnd = xs(rnd);
      i_swm_bus_master.gap = int'(rnd[22:21]) * 16;
      wr1(DEV_ADDR, {rnd[7], 2'h0, rnd[12:8]}, {6'h00, rnd[16], |rnd[19:17]}, 1'b1);
      if (rnd[24]) rdf();
    end
    rdf();
    test_done();
  end
endmodule // i2c_switch_matrix_control_tb_top

`default_nettype wire
